//--- core/tbf_defs.vh
// Timing, frame and checksum constants for the Type B reader framer.
`ifndef TBF_DEFS_VH
`define TBF_DEFS_VH
`define TBF_CLK_PS 100000
`define TBF_ETU_PS 9439500
`define TBF_ETU_CYC (`TBF_ETU_PS / `TBF_CLK_PS)
`define TBF_HALF_CYC (`TBF_ETU_CYC / 2)
`define TBF_EGT_PS 19000000
`define TBF_EGT_CYC (`TBF_EGT_PS / `TBF_CLK_PS)
`define TBF_GAP_MAX (`TBF_HALF_CYC + `TBF_EGT_CYC)
`define TBF_SOF_LOW_MIN 10
`define TBF_SOF_LOW_MAX 11
`define TBF_SOF_HIGH_MIN 2
`define TBF_SOF_HIGH_MAX 3
`define TBF_TX_SOF_LOW 4'HA
`define TBF_TX_SOF_LAST 4'HB
`define TBF_TX_EOF_LAST 4'H9
`define TBF_BYTE_LAST 4'H9
`define TBF_POLL_WAIT 20'H00020
`define TBF_FWI_RST 4'H4
`define TBF_FWI_MAX 4'HE
`define TBF_CRC_INIT 16'HFFFF
`define TBF_CRC_POLY_REF 16'H8408
`define TBF_ATQB_CODE 8'H50
`define TBF_ATQB_FWI_IDX 8'H0B
`endif

//--- core/tbf_framer.v
// Type B reader framer: transmit framing, receive decoding, CRC and response timing.
`timescale 1ns/10ps
`include "tbf_defs.vh"

module tbf_framer (
   input wire mclk_i,
   input wire rst_i,
   input wire [7:0] tx_data_i,
   input wire tx_valid_i,
   input wire tx_last_i,
   input wire tx_poll_i,
   output reg tx_ready_o,
   output reg tx_mod_o,
   output reg rf_on_o,
   output reg tx_underrun_o,
   input wire rx_sc_on_i,
   input wire rx_bit_i,
   output reg [7:0] rx_data_o,
   output reg rx_valid_o,
   input wire rx_ready_i,
   output reg rx_done_o,
   output reg rx_crc_err_o,
   output reg rx_frame_err_o,
   output reg rx_timeout_o,
   output reg rx_overrun_o,
   output reg [3:0] fwi_o
);

   localparam [3:0] S_IDLE = 4'H0;
   localparam [3:0] S_TSOF = 4'H1;
   localparam [3:0] S_TDATA = 4'H2;
   localparam [3:0] S_TEOF = 4'H3;
   localparam [3:0] S_WAIT = 4'H4;
   localparam [3:0] S_TR1 = 4'H5;
   localparam [3:0] S_RSOFL = 4'H6;
   localparam [3:0] S_RSOFH = 4'H7;
   localparam [3:0] S_RBYTE = 4'H8;
   localparam [3:0] S_RGAP = 4'H9;

   // Reflected form of the 1021 polynomial, so bytes are folded in LSB first.
   function [15:0] crc_byte;
      input [15:0] crc;
      input [7:0] data;
      integer i;
      reg [15:0] c;
      begin
         c = crc ^ {8'H00, data};
         for (i = 0; i < 8; i = i + 1) begin
            if (c[0]) begin
               c = (c >> 1) ^ `TBF_CRC_POLY_REF;
            end else begin
               c = c >> 1;
            end
         end
         crc_byte = c;
      end
   endfunction

   reg [3:0] state_reg;
   reg [6:0] etu_cnt_reg;
   reg [3:0] bit_reg;
   reg [9:0] tx_sh_reg;
   reg [1:0] tx_phase_reg;
   reg [15:0] crc_reg;
   reg [7:0] hold_reg;
   reg hold_full_reg;
   reg hold_last_reg;
   reg last_sent_reg;
   reg poll_reg;
   reg [19:0] wait_reg;
   reg [7:0] gap_reg;
   reg [7:0] rx_sh_reg;
   reg [7:0] rx_cnt_reg;
   reg atqb_reg;
   reg [3:0] fwi_cap_reg;
   reg rx_prev_reg;
   reg [7:0] spare_reg;
   reg spare_full_reg;
   reg push_reg;
   reg [7:0] push_data_reg;

   wire etu_tick = (etu_cnt_reg == `TBF_ETU_CYC - 1);
   wire mid_tick = (etu_cnt_reg == `TBF_HALF_CYC);
   wire rx_fall = rx_prev_reg & ~rx_bit_i;
   wire take = tx_valid_i & tx_ready_o;
   wire byte_end = (state_reg == S_TDATA) && etu_tick && (bit_reg == `TBF_BYTE_LAST);
   wire use_hold = byte_end && (tx_phase_reg == 2'H0) && hold_full_reg;
   wire [19:0] wait_lim = poll_reg ? `TBF_POLL_WAIT : (`TBF_POLL_WAIT << fwi_o);
   wire rx_active = (state_reg == S_TR1) || (state_reg == S_RSOFL) ||
                    (state_reg == S_RSOFH) || (state_reg == S_RBYTE) ||
                    (state_reg == S_RGAP);

   reg hold_full_next;
   always @* begin
      hold_full_next = hold_full_reg;
      if (use_hold || (state_reg == S_IDLE && hold_full_reg)) begin
         hold_full_next = 1'b0;
      end
      if (take) begin
         hold_full_next = 1'b1;
      end
   end

   // Receive side cannot stall the card, so a full two-entry buffer reports overrun.
   reg rx_valid_next;
   reg [7:0] rx_data_next;
   reg spare_full_next;
   reg [7:0] spare_next;
   reg ovf_next;
   always @* begin
      rx_valid_next = rx_valid_o;
      rx_data_next = rx_data_o;
      spare_full_next = spare_full_reg;
      spare_next = spare_reg;
      ovf_next = 1'b0;
      if (rx_valid_o && rx_ready_i) begin
         rx_valid_next = spare_full_reg;
         rx_data_next = spare_reg;
         spare_full_next = 1'b0;
      end
      if (push_reg) begin
         if (!rx_valid_next) begin
            rx_valid_next = 1'b1;
            rx_data_next = push_data_reg;
         end else if (!spare_full_next) begin
            spare_full_next = 1'b1;
            spare_next = push_data_reg;
         end else begin
            ovf_next = 1'b1;
         end
      end
   end

   always @(posedge mclk_i) begin
      if (rst_i) begin
         state_reg <= S_IDLE;
         etu_cnt_reg <= 7'H00;
         bit_reg <= 4'H0;
         tx_sh_reg <= 10'H3FF;
         tx_phase_reg <= 2'H0;
         crc_reg <= `TBF_CRC_INIT;
         hold_reg <= 8'H00;
         hold_full_reg <= 1'b0;
         hold_last_reg <= 1'b0;
         last_sent_reg <= 1'b0;
         poll_reg <= 1'b0;
         wait_reg <= 20'H00000;
         gap_reg <= 8'H00;
         rx_sh_reg <= 8'H00;
         rx_cnt_reg <= 8'H00;
         atqb_reg <= 1'b0;
         fwi_cap_reg <= `TBF_FWI_RST;
         rx_prev_reg <= 1'b1;
         spare_reg <= 8'H00;
         spare_full_reg <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= 8'H00;
         tx_ready_o <= 1'b0;
         tx_mod_o <= 1'b0;
         rf_on_o <= 1'b0;
         tx_underrun_o <= 1'b0;
         rx_data_o <= 8'H00;
         rx_valid_o <= 1'b0;
         rx_done_o <= 1'b0;
         rx_crc_err_o <= 1'b0;
         rx_frame_err_o <= 1'b0;
         rx_timeout_o <= 1'b0;
         rx_overrun_o <= 1'b0;
         fwi_o <= `TBF_FWI_RST;
      end else begin
         rf_on_o <= 1'b1;
         rx_prev_reg <= rx_bit_i;
         hold_full_reg <= hold_full_next;
         tx_ready_o <= ~hold_full_next;
         if (take) begin
            hold_reg <= tx_data_i;
            hold_last_reg <= tx_last_i;
         end
         rx_valid_o <= rx_valid_next;
         rx_data_o <= rx_data_next;
         spare_full_reg <= spare_full_next;
         spare_reg <= spare_next;
         rx_overrun_o <= ovf_next;
         push_reg <= 1'b0;
         tx_underrun_o <= 1'b0;
         rx_done_o <= 1'b0;
         rx_crc_err_o <= 1'b0;
         rx_frame_err_o <= 1'b0;
         rx_timeout_o <= 1'b0;
         etu_cnt_reg <= etu_tick ? 7'H00 : etu_cnt_reg + 7'H01;
         case (state_reg)
            S_IDLE: begin
               tx_mod_o <= 1'b0;
               if (hold_full_reg) begin
                  state_reg <= S_TSOF;
                  etu_cnt_reg <= 7'H00;
                  bit_reg <= 4'H0;
                  poll_reg <= tx_poll_i;
                  crc_reg <= `TBF_CRC_INIT;
                  tx_sh_reg <= {1'b1, hold_reg, 1'b0};
                  crc_reg <= crc_byte(`TBF_CRC_INIT, hold_reg);
                  last_sent_reg <= hold_last_reg;
                  tx_phase_reg <= 2'H0;
               end
            end
            S_TSOF: begin
               tx_mod_o <= (bit_reg < `TBF_TX_SOF_LOW);
               if (etu_tick) begin
                  bit_reg <= bit_reg + 4'H1;
                  if (bit_reg == `TBF_TX_SOF_LAST) begin
                     state_reg <= S_TDATA;
                     bit_reg <= 4'H0;
                  end
               end
            end
            S_TDATA: begin
               tx_mod_o <= ~tx_sh_reg[0];
               if (etu_tick) begin
                  tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                  bit_reg <= bit_reg + 4'H1;
               end
               // The next byte is chosen at the stop bit's end so no gap appears.
               if (byte_end) begin
                  bit_reg <= 4'H0;
                  if (tx_phase_reg == 2'H0 && !last_sent_reg && hold_full_reg) begin
                     tx_sh_reg <= {1'b1, hold_reg, 1'b0};
                     crc_reg <= crc_byte(crc_reg, hold_reg);
                     last_sent_reg <= hold_last_reg;
                  end else if (tx_phase_reg == 2'H0) begin
                     tx_sh_reg <= {1'b1, crc_reg[7:0], 1'b0};
                     tx_phase_reg <= 2'H1;
                     tx_underrun_o <= ~last_sent_reg;
                  end else if (tx_phase_reg == 2'H1) begin
                     tx_sh_reg <= {1'b1, crc_reg[15:8], 1'b0};
                     tx_phase_reg <= 2'H2;
                  end else begin
                     state_reg <= S_TEOF;
                  end
               end
            end
            S_TEOF: begin
               tx_mod_o <= 1'b1;
               if (etu_tick) begin
                  bit_reg <= bit_reg + 4'H1;
                  if (bit_reg == `TBF_TX_EOF_LAST) begin
                     state_reg <= S_WAIT;
                     wait_reg <= 20'H00000;
                  end
               end
            end
            S_WAIT: begin
               tx_mod_o <= 1'b0;
               if (rx_sc_on_i) begin
                  state_reg <= S_TR1;
                  crc_reg <= `TBF_CRC_INIT;
                  rx_cnt_reg <= 8'H00;
                  atqb_reg <= 1'b0;
               end else if (etu_tick) begin
                  wait_reg <= wait_reg + 20'H00001;
                  if (wait_reg + 20'H00001 >= wait_lim) begin
                     state_reg <= S_IDLE;
                     rx_timeout_o <= 1'b1;
                  end
               end
            end
            S_TR1: begin
               tx_mod_o <= 1'b0;
               if (rx_fall) begin
                  state_reg <= S_RSOFL;
                  etu_cnt_reg <= 7'H00;
                  bit_reg <= 4'H0;
               end
            end
            S_RSOFL: begin
               tx_mod_o <= 1'b0;
               if (mid_tick) begin
                  if (!rx_bit_i) begin
                     bit_reg <= bit_reg + 4'H1;
                     if (bit_reg >= `TBF_SOF_LOW_MAX) begin
                        state_reg <= S_IDLE;
                        rx_frame_err_o <= 1'b1;
                     end
                  end else if (bit_reg < `TBF_SOF_LOW_MIN) begin
                     state_reg <= S_IDLE;
                     rx_frame_err_o <= 1'b1;
                  end else begin
                     state_reg <= S_RSOFH;
                     bit_reg <= 4'H1;
                  end
               end
            end
            S_RSOFH: begin
               tx_mod_o <= 1'b0;
               if (rx_fall) begin
                  etu_cnt_reg <= 7'H00;
                  bit_reg <= 4'H0;
                  if (bit_reg >= `TBF_SOF_HIGH_MIN) begin
                     state_reg <= S_RBYTE;
                  end else begin
                     state_reg <= S_IDLE;
                     rx_frame_err_o <= 1'b1;
                  end
               end else if (mid_tick) begin
                  bit_reg <= bit_reg + 4'H1;
                  if (bit_reg >= `TBF_SOF_HIGH_MAX) begin
                     state_reg <= S_IDLE;
                     rx_frame_err_o <= 1'b1;
                  end
               end
            end
            S_RBYTE: begin
               tx_mod_o <= 1'b0;
               if (mid_tick) begin
                  bit_reg <= bit_reg + 4'H1;
                  if (bit_reg == 4'H0 && rx_bit_i) begin
                     state_reg <= S_IDLE;
                     rx_frame_err_o <= 1'b1;
                  end else if (bit_reg != 4'H0 && bit_reg != `TBF_BYTE_LAST) begin
                     rx_sh_reg <= {rx_bit_i, rx_sh_reg[7:1]};
                  end else if (bit_reg == `TBF_BYTE_LAST) begin
                     if (rx_bit_i) begin
                        state_reg <= S_RGAP;
                        gap_reg <= 8'H00;
                        push_reg <= 1'b1;
                        push_data_reg <= rx_sh_reg;
                        crc_reg <= crc_byte(crc_reg, rx_sh_reg);
                        rx_cnt_reg <= rx_cnt_reg + 8'H01;
                        if (rx_cnt_reg == 8'H00 && rx_sh_reg == `TBF_ATQB_CODE) begin
                           atqb_reg <= poll_reg;
                        end
                        if (rx_cnt_reg == `TBF_ATQB_FWI_IDX) begin
                           fwi_cap_reg <= (rx_sh_reg[7:4] > `TBF_FWI_MAX) ?
                                          `TBF_FWI_MAX : rx_sh_reg[7:4];
                        end
                     end else if (rx_sh_reg == 8'H00) begin
                        // Ten low ETUs: end-of-frame.
                        state_reg <= S_IDLE;
                        rx_done_o <= 1'b1;
                        if (crc_reg != 16'H0000 || rx_cnt_reg < 8'H02) begin
                           rx_crc_err_o <= 1'b1;
                        end else if (atqb_reg && rx_cnt_reg > `TBF_ATQB_FWI_IDX) begin
                           fwi_o <= fwi_cap_reg;
                        end
                     end else begin
                        state_reg <= S_IDLE;
                        rx_frame_err_o <= 1'b1;
                     end
                  end
               end
            end
            S_RGAP: begin
               tx_mod_o <= 1'b0;
               gap_reg <= gap_reg + 8'H01;
               if (rx_fall) begin
                  state_reg <= S_RBYTE;
                  etu_cnt_reg <= 7'H00;
                  bit_reg <= 4'H0;
               end else if (gap_reg >= `TBF_GAP_MAX) begin
                  state_reg <= S_IDLE;
                  rx_frame_err_o <= 1'b1;
               end
            end
            default: begin
               state_reg <= S_IDLE;
               tx_mod_o <= 1'b0;
            end
         endcase
         // A subcarrier lost mid-answer ends the frame as broken.
         if (rx_active && !rx_sc_on_i) begin
            state_reg <= S_IDLE;
            rx_frame_err_o <= 1'b1;
         end
      end
   end

endmodule // tbf_framer

//--- sim/tbf_framer_checker.sv
// Port assertions for the Type B reader framer.
`timescale 1ns/10ps
`include "tbf_defs.vh"
module tbf_checker (
   input wire mclk_i,
   input wire rst_i,
   input wire tx_valid_i,
   input wire tx_ready_o,
   input wire tx_mod_o,
   input wire rf_on_o,
   input wire rx_sc_on_i,
   input wire [7:0] rx_data_o,
   input wire rx_valid_o,
   input wire rx_ready_i,
   input wire rx_done_o,
   input wire rx_crc_err_o,
   input wire [3:0] fwi_o
);
   reg mod_prev_reg;
   reg [15:0] run_reg;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Counts how long the current level has stood, so symbol lengths can be judged.
   always @(posedge mclk_i) begin
      mod_prev_reg <= tx_mod_o;
      if (rst_i || tx_mod_o != mod_prev_reg) begin
         run_reg <= 16'H0001;
      end else begin
         run_reg <= run_reg + 16'H0001;
      end
   end
   carrier_on_a: assert property (!$past(rst_i) |-> rf_on_o)
      else $error("carrier off after reset");
   crc_with_done_a: assert property (rx_crc_err_o |-> rx_done_o)
      else $error("checksum flag without end of frame");
   done_pulse_a: assert property (rx_done_o |=> !rx_done_o)
      else $error("end of frame flag too long");
   rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("stalled byte not held");
   tx_take_a: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
      else $error("ready stayed high after byte taken");
   fwi_range_a: assert property (fwi_o <= 4'HE)
      else $error("wait index above 14");
   symbol_len_a: assert property ($fell(tx_mod_o) |-> run_reg % `TBF_ETU_CYC == 0)
      else $error("modulated run not whole ETUs");
   quiet_wait_a: assert property (rx_sc_on_i |-> !tx_mod_o)
      else $error("field modulated during answer");
endmodule // tbf_checker
bind tbf_framer tbf_checker chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_i),
   .tx_ready_o(tx_ready_o), .tx_mod_o(tx_mod_o), .rf_on_o(rf_on_o), .rx_sc_on_i(rx_sc_on_i),
   .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
   .rx_done_o(rx_done_o), .rx_crc_err_o(rx_crc_err_o), .fwi_o(fwi_o));

//--- sim/tbf_card_model.sv
// Behavioural card answering over the demodulated subcarrier lines.
`timescale 1ns/10ps
`include "tbf_defs.vh"
module tbf_card_model (
   input wire mclk_i,
   output reg sc_on_o,
   output reg bit_o
);
   localparam int E = `TBF_ETU_CYC;
   initial begin
      sc_on_o = 1'H0;
      bit_o = 1'H1;
   end
   // Without subcarrier the demodulator gives noise, so the line toggles every cycle.
   always @(negedge mclk_i) begin
      if (!sc_on_o) bit_o = ~bit_o;
   end
   task drive(input logic b, input int cyc);
      bit_o = b;
      repeat (cyc) @(posedge mclk_i);
      #1;
   endtask
   task send(input logic [127:0] d, input int n, input int guard, input int gap);
      repeat (guard * E) @(posedge mclk_i);
      #1;
      sc_on_o = 1'H1;
      drive(1'H1, 10 * E);
      drive(1'H0, 10 * E);
      drive(1'H1, 2 * E);
      for (int i = 0; i < n; i++) begin
         drive(1'H0, E);
         for (int j = 0; j < 8; j++) drive(d[8 * i + j], E);
         drive(1'H1, E + gap);
      end
      drive(1'H0, 10 * E);
      drive(1'H1, E);
      sc_on_o = 1'H0;
   endtask
endmodule // tbf_card_model

//--- sim/testbench.sv
// Self-checking bench for the Type B reader framer against a card model.
`timescale 1ns/10ps
`include "tbf_defs.vh"
module testbench;
   localparam int E = `TBF_ETU_CYC;
   reg mclk_i = 1'H0;
   reg rst_i = 1'H1;
   reg [7:0] tx_data_i = 8'H00;
   reg tx_valid_i = 1'H0;
   reg tx_last_i = 1'H0;
   reg tx_poll_i = 1'H0;
   reg rx_ready_i = 1'H1;
   wire tx_ready_o, tx_mod_o, rf_on_o, rx_sc_on_i, rx_bit_i, rx_valid_o, rx_done_o;
   wire rx_crc_err_o, rx_timeout_o, rx_overrun_o, tx_underrun_o, rx_frame_err_o;
   wire [7:0] rx_data_o;
   wire [3:0] fwi_o;
   int fail_count = 0;
   int total_checks = 0;
   int done_n = 0;
   int crc_n = 0;
   int to_n = 0;
   int ovr_n = 0;
   int un_n = 0;
   int fe_n = 0;
   logic [7:0] rxq[$];
   always #50 mclk_i = ~mclk_i;
   tbf_framer dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .tx_data_i(tx_data_i),
      .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i), .tx_poll_i(tx_poll_i),
      .tx_ready_o(tx_ready_o), .tx_mod_o(tx_mod_o), .rf_on_o(rf_on_o),
      .tx_underrun_o(tx_underrun_o),
      .rx_sc_on_i(rx_sc_on_i), .rx_bit_i(rx_bit_i), .rx_data_o(rx_data_o),
      .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_done_o(rx_done_o),
      .rx_crc_err_o(rx_crc_err_o), .rx_frame_err_o(rx_frame_err_o),
      .rx_timeout_o(rx_timeout_o),
      .rx_overrun_o(rx_overrun_o), .fwi_o(fwi_o));
   tbf_card_model card_u (.mclk_i(mclk_i), .sc_on_o(rx_sc_on_i), .bit_o(rx_bit_i));
   always @(posedge mclk_i) begin
      if (rx_valid_o === 1'H1 && rx_ready_i) rxq.push_back(rx_data_o);
      if (rx_done_o === 1'H1) done_n++;
      if (rx_crc_err_o === 1'H1) crc_n++;
      if (rx_timeout_o === 1'H1) to_n++;
      if (rx_overrun_o === 1'H1) ovr_n++;
      if (tx_underrun_o === 1'H1) un_n++;
      if (rx_frame_err_o === 1'H1) fe_n++;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task give_up;
      check(32'H0, 32'H1);
      test_done;
   endtask
   task automatic wait_on(ref int cnt, input int base, input int lim, output int k);
      k = 0;
      while (cnt == base) begin
         if (k++ > lim) give_up;
         @(posedge mclk_i);
         #1;
      end
   endtask
   // Reflected form, no final inversion, low byte goes out first.
   function automatic logic [15:0] crc_b(input logic [127:0] d, input int n);
      logic [15:0] c = `TBF_CRC_INIT;
      for (int i = 0; i < 8 * n; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'H8408 : c >> 1;
      return c;
   endfunction
   task etu_bits(input int cnt, output logic [15:0] v);
      v = 16'H0000;
      for (int i = 0; i < cnt; i++) begin
         v[i] = tx_mod_o;
         repeat (E) @(posedge mclk_i);
         #1;
      end
   endtask
   task tx_frame(input logic [127:0] d, input int n, input logic poll);
      logic [15:0] v;
      logic [127:0] f;
      int j;
      int k;
      f = d | ({112'H0, crc_b(d, n)} << (8 * n));
      fork
         for (int i = 0; i < n; i++) begin
            tx_data_i = d[8 * i +: 8];
            tx_valid_i = 1'H1;
            tx_last_i = (i == n - 1);
            tx_poll_i = poll;
            j = 0;
            while (tx_ready_o !== 1'H1) begin
               if (j++ > 3000) give_up;
               @(posedge mclk_i);
               #1;
            end
            @(posedge mclk_i);
            #1;
            if (i == n - 1) tx_valid_i = 1'H0;
         end
         begin
            k = 0;
            while (tx_mod_o !== 1'H1) begin
               if (k++ > 2000) give_up;
               @(posedge mclk_i);
               #1;
            end
            repeat (E / 2) @(posedge mclk_i);
            #1;
            etu_bits(12, v);
            check(v, 16'H03FF);
            for (int i = 0; i < n + 2; i++) begin
               etu_bits(10, v);
               check(v, {7'H00, ~f[8 * i +: 8], 1'H1});
            end
            etu_bits(11, v);
            check(v, 16'H03FF);
         end
      join
   endtask
   task poll_timeout;
      int k;
      tx_frame(128'H080005, 3, 1'H1);
      wait_on(to_n, to_n, 4000, k);
      check(k > 28 * E && k <= 32 * E, 1'H1);
   endtask
   task atqb(input logic [3:0] fwi, input logic [3:0] exp);
      logic [127:0] d;
      int k;
      int c;
      d = {32'H0, fwi, 4'H1, 88'H00_8181_1234_5678_ABCD_EF_50};
      d = d | ({112'H0, crc_b(d, 12)} << 96);
      tx_frame(128'H000005, 3, 1'H1);
      rxq.delete();
      c = crc_n;
      k = done_n;
      card_u.send(d, 14, 8, 180);
      wait_on(done_n, k, 300, k);
      check(rxq.size(), 14);
      for (int i = 0; i < 14; i++) check(rxq[i], d[8 * i +: 8]);
      check(crc_n - c, 0);
      check(fwi_o, exp);
   endtask
   task fwt_timeout;
      int k;
      tx_frame(128'H00, 1, 1'H0);
      wait_on(to_n, to_n, 14000, k);
      check(k > 124 * E && k <= 128 * E, 1'H1);
   endtask
   task crc_overrun;
      logic [127:0] d;
      int c;
      int o;
      int k;
      d = 128'H0055AA;
      d = d | ({112'H0, ~crc_b(d, 3)} << 24);
      tx_frame(128'H00, 1, 1'H0);
      rx_ready_i = 1'H0;
      rxq.delete();
      c = crc_n;
      o = ovr_n;
      k = done_n;
      card_u.send(d, 5, 8, 0);
      wait_on(done_n, k, 300, k);
      check(crc_n - c, 1);
      check(ovr_n > o, 1'H1);
      check(fwi_o, 4'H2);
      rx_ready_i = 1'H1;
      repeat (6) @(posedge mclk_i);
      #1;
      check(rxq.size(), 2);
      check({rxq[1], rxq[0]}, 16'H55AA);
      check(rx_valid_o, 1'H0);
   endtask
   // A host that stalls mid-frame still gets a closed frame; the card then overruns its gap.
   task underrun_gap;
      int u;
      int f;
      int k;
      int j;
      u = un_n;
      f = fe_n;
      k = done_n;
      tx_data_i = 8'H05;
      tx_last_i = 1'H0;
      tx_poll_i = 1'H0;
      tx_valid_i = 1'H1;
      j = 0;
      while (tx_ready_o !== 1'H1) begin
         if (j++ > 100) give_up;
         @(posedge mclk_i);
         #1;
      end
      @(posedge mclk_i);
      #1;
      tx_valid_i = 1'H0;
      wait_on(un_n, u, 3000, j);
      repeat (30 * E) @(posedge mclk_i);
      #1;
      card_u.send(128'H34, 1, 8, 200);
      check(un_n - u, 1);
      check(fe_n - f, 1);
      check(done_n - k, 0);
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      #1;
      rst_i = 1'H0;
      repeat (3) @(posedge mclk_i);
      #1;
      check(rf_on_o, 1'H1);
      check(fwi_o, `TBF_FWI_RST);
      poll_timeout;
      atqb(4'HF, 4'HE);
      atqb(4'H2, 4'H2);
      fwt_timeout;
      crc_overrun;
      underrun_gap;
      test_done;
   end
endmodule // testbench
